/* sim/flq_far_side.sv */
// Behavioural protection sense network that drives the latch comparator from the gated drive.
module flq_far_side (
    input wire logic i_sys_clk,
    input wire logic i_drv,
    input wire logic [2:0] i_mode,
    output logic o_above_latch_threshold
);
    timeunit 1ns;
    timeprecision 1ps;
    // --------------------------------------------------------
    // Off-time pulse shaping
    // --------------------------------------------------------
    // Modes: 0 quiet, 1 long fault, 2 spike one sample short, 3 spike in blanking, 4 high in on-time.
    logic drv_q = 1'b0;
    logic [7:0] cnt_r = 8'hff;
    logic [7:0] dly;
    logic [7:0] wid;
    assign dly = (i_mode == 3'h3) ? 8'h00 : 8'h06;
    assign wid = (i_mode == 3'h1) ? 8'h06 : 8'h02;
    always @(posedge i_sys_clk) begin
        drv_q <= i_drv;
        if (drv_q && !i_drv) begin
            cnt_r <= 8'h00;
        end else if (cnt_r != 8'hff) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    // A spike that lands in the blanking window is kept short so it cannot leak past it.
    assign o_above_latch_threshold = (i_mode == 3'h4) ? i_drv :
        ((i_mode != 3'h0) && !i_drv && (cnt_r >= dly) && (cnt_r < dly + wid));
endmodule // flq_far_side

/* sim/test_fault_latch_qualifier.sv */
// Self-checking bench of the fault latch qualifier.
module test_fault_latch_qualifier;
    timeunit 1ns;
    timeprecision 1ps;
    import flq_pkg::*;
    // --------------------------------------------------------
    // Signals and design
    // --------------------------------------------------------
    typedef struct packed {logic [2:0] mode; logic [2:0] cnt; logic lat;} flq_row_s;
    localparam flq_row_s ROWS [11] = '{'{3'h1, 3'h1, 1'b0}, '{3'h1, 3'h2, 1'b0},
        '{3'h2, 3'h2, 1'b0}, '{3'h1, 3'h1, 1'b0}, '{3'h3, 3'h1, 1'b0}, '{3'h1, 3'h1, 1'b0},
        '{3'h4, 3'h1, 1'b0}, '{3'h1, 3'h1, 1'b0}, '{3'h1, 3'h2, 1'b0}, '{3'h1, 3'h3, 1'b0},
        '{3'h1, 3'h4, 1'b1}};
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic drv_req = 1'b0;
    logic cyc = 1'b0;
    logic srst = 1'b0;
    logic vlow = 1'b0;
    logic vhys = 1'b0;
    logic [2:0] mode = 3'h0;
    logic cmp;
    logic o_drv;
    logic last_on;
    flq_stat_s stat;
    int num_errors = 0;
    int n_tests = 0;
    int bad_drv = 0;
    int cyc_cnt = 0;
    fault_latch_qualifier #(.BLANK(4), .QUAL(3), .EVENTS(4)) i_dut (.i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b), .i_drv_req(drv_req), .i_cycle_start(cyc),
        .i_above_latch_threshold(cmp), .i_below_supply_reset_level(srst),
        .i_supply_below_min(vlow), .i_supply_above_hyst(vhys), .o_drv(o_drv), .o_stat(stat));
    flq_far_side i_far (.i_sys_clk(i_sys_clk), .i_drv(o_drv), .i_mode(mode),
        .o_above_latch_threshold(cmp));
    initial begin
        forever #2.5 i_sys_clk = ~i_sys_clk;
    end
    // Any drive seen while the latch is set is a leak, however short.
    always @(posedge i_sys_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (stat.latched === 1'b1 && o_drv !== 1'b0) begin
            bad_drv <= bad_drv + 1;
        end
        if (cyc_cnt == 5000) begin
            num_errors = num_errors + 1;
            end_of_test();
        end
    end
    // --------------------------------------------------------
    // Tasks
    // --------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic run_cycle(input logic [2:0] m);
        mode = m;
        cyc = 1'b1;
        drv_req = 1'b1;
        @(posedge i_sys_clk);
        #1 cyc = 1'b0;
        repeat (7) @(posedge i_sys_clk);
        #1 last_on = o_drv;
        drv_req = 1'b0;
        repeat (20) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic wait_edges(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // --------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------
    initial begin
        repeat (8) @(posedge i_sys_clk);
        #1 chk({2'h0, o_drv, stat}, 8'h00);
        i_rst_b = 1'b1;
        wait_edges(2);
        chk({2'h0, o_drv, stat}, 8'h00);
        foreach (ROWS[k]) begin
            run_cycle(ROWS[k].mode);
            chk({5'h0, stat.evt_cnt}, {5'h0, ROWS[k].cnt});
            chk({7'h0, stat.latched}, {7'h0, ROWS[k].lat});
        end
        $display("test successive events done");
        run_cycle(3'h0);
        chk({7'h0, last_on}, 8'h00);
        chk({7'h0, stat.latched}, 8'h01);
        vlow = 1'b1;
        wait_edges(4);
        chk({7'h0, stat.hiccup}, 8'h01);
        vlow = 1'b0;
        vhys = 1'b1;
        wait_edges(4);
        chk({7'h0, stat.hiccup}, 8'h00);
        vhys = 1'b0;
        chk({7'h0, stat.latched}, 8'h01);
        srst = 1'b1;
        wait_edges(4);
        chk({3'h0, stat}, 8'h00);
        srst = 1'b0;
        wait_edges(3);
        chk(bad_drv[7:0], 8'h00);
        $display("test latch and hiccup done");
        run_cycle(3'h1);
        chk({7'h0, last_on}, 8'h01);
        run_cycle(3'h1);
        chk({5'h0, stat.evt_cnt}, 8'h02);
        srst = 1'b1;
        wait_edges(4);
        chk({5'h0, stat.evt_cnt}, 8'h00);
        srst = 1'b0;
        wait_edges(3);
        run_cycle(3'h1);
        drv_req = 1'b1;
        wait_edges(2);
        i_rst_b = 1'b0;
        #1 chk({2'h0, o_drv, stat}, 8'h00);
        drv_req = 1'b0;
        wait_edges(2);
        i_rst_b = 1'b1;
        wait_edges(2);
        chk({2'h0, o_drv, stat}, 8'h00);
        $display("test supply reset and mid-run reset done");
        end_of_test();
    end
endmodule // test_fault_latch_qualifier

/* src/fault_latch_qualifier.sv */
// Fault qualification, successive-event counter and latch-off control of the switching controller.
//
// Contract
// - Once latched off, every further drive pulse is suppressed at once.
// - The latch holds, with the supply hiccuping, until the supply-reset indication clears it.
// - After each driver turn-off edge the comparator is ignored for a fixed blanking interval.
// - A comparator high counts as an event only if it lasts the minimum qualification time.
// - Qualified events are counted and the part latches when the count reaches 4.
// - Events are judged per switching cycle, in the off-time of 4 consecutive cycles.
module fault_latch_qualifier #(
    parameter int BLANK = flq_pkg::BLANK_CYC,
    parameter int QUAL = flq_pkg::QUAL_CYC,
    parameter int EVENTS = flq_pkg::EVT_LATCH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_drv_req,
    input wire logic i_cycle_start,
    input wire logic i_above_latch_threshold,
    input wire logic i_below_supply_reset_level,
    input wire logic i_supply_below_min,
    input wire logic i_supply_above_hyst,
    output logic o_drv,
    output flq_pkg::flq_stat_s o_stat
);
    import flq_pkg::*;

    localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(EVENTS - 1);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Comparator and supply monitors are analog and asynchronous to the oscillator clock.
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    wire [SYNC_W-1:0] async_in = {i_supply_above_hyst, i_supply_below_min,
                                  i_below_supply_reset_level, i_above_latch_threshold};

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= async_in;
            sync2_r <= sync1_r;
        end
    end

    wire cmp_s = sync2_r[SY_CMP];
    wire srst_s = sync2_r[SY_SRST];
    wire vlow_s = sync2_r[SY_VLOW];
    wire vhys_s = sync2_r[SY_VHYS];

    // ------------------------------------------------------------
    // Qualification
    // ------------------------------------------------------------
    logic evt;
    logic drv_r;

    flq_qualify #(
        .BLANK(BLANK),
        .QUAL(QUAL)
    ) u_qualify (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_drv(drv_r),
        .i_cmp(cmp_s),
        .o_event(evt)
    );

    // ------------------------------------------------------------
    // Counter and latch
    // ------------------------------------------------------------
    logic latched_r, latched_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic cyc_hit_r, cyc_hit_nxt;
    logic hiccup_r, hiccup_nxt;
    logic drv_nxt;

    wire latch_set = evt & (cnt_r == CNT_LAST) & ~srst_s;
    wire cyc_miss = i_cycle_start & ~cyc_hit_r & ~evt;

    assign latched_nxt = srst_s ? 1'b0 : (latched_r | latch_set);
    // The gate uses the next latch state so the deciding edge already drops the pulse.
    assign drv_nxt = i_drv_req & ~latched_nxt;
    assign cnt_nxt = srst_s ? CNT_RST :
                     (evt && cnt_r != CNT_W'(EVENTS)) ? cnt_r + 1'b1 :
                     cyc_miss ? CNT_RST : cnt_r;
    // A new event wins over the end-of-cycle clear of the hit flag.
    assign cyc_hit_nxt = evt ? 1'b1 : (i_cycle_start ? 1'b0 : cyc_hit_r);
    // While latched the start-up source charges below the minimum and stops above the hysteresis.
    assign hiccup_nxt = !latched_nxt ? 1'b0 :
                        vlow_s ? 1'b1 : vhys_s ? 1'b0 : hiccup_r;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            latched_r <= 1'b0;
            cnt_r <= CNT_RST;
            cyc_hit_r <= 1'b0;
            hiccup_r <= 1'b0;
            drv_r <= 1'b0;
        end else begin
            latched_r <= latched_nxt;
            cnt_r <= cnt_nxt;
            cyc_hit_r <= cyc_hit_nxt;
            hiccup_r <= hiccup_nxt;
            drv_r <= drv_nxt;
        end
    end

    assign o_drv = drv_r;
    assign o_stat = '{latched: latched_r, hiccup: hiccup_r, evt_cnt: cnt_r};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_last_event;
        evt && cnt_r == CNT_LAST && !srst_s;
    endsequence

    sequence s_latched_quiet;
        latched_r && !o_drv;
    endsequence

    a_drv_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_last_event |=> s_latched_quiet)
        else $error("Drive pulse present after the latch decision.");

    a_drv_latched: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        latched_r |-> !o_drv)
        else $error("Drive active while latched off.");

    a_latch_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        latched_r && !srst_s |=> latched_r)
        else $error("Latch released without supply reset.");

    a_latch_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        srst_s |=> !latched_r && !o_stat.hiccup && cnt_r == CNT_RST)
        else $error("Supply reset did not clear latch and count.");

    a_hiccup_band: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        latched_r && !srst_s && vlow_s |=> o_stat.hiccup)
        else $error("Hiccup charge not restarted at the supply minimum.");

    a_latch_four: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(latched_r) |-> $past(evt) && $past(cnt_r) == CNT_LAST)
        else $error("Latch entered without the fourth successive event.");

    a_cnt_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        cyc_miss && !srst_s |=> cnt_r == CNT_RST)
        else $error("Event count kept after a cycle without an event.");

    a_cnt_step: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        evt && !srst_s && cnt_r < CNT_LAST |=> cnt_r == $past(cnt_r) + 1'b1 && !latched_r)
        else $error("Event count did not advance by one per cycle.");

    sequence s_open_gate;
        !latched_r && !evt;
    endsequence

    sequence s_band_top;
        latched_r && !srst_s && !vlow_s && vhys_s;
    endsequence

    a_drv_follow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_open_gate |=> o_drv == $past(i_drv_req))
        else $error("Drive did not follow the request while not latched.");

    a_drv_source: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_drv |-> $past(i_drv_req))
        else $error("Drive pulse without a drive request.");

    a_hiccup_off: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        !latched_r |-> !o_stat.hiccup)
        else $error("Hiccup charge active while not latched.");

    a_hiccup_stop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_band_top |=> !o_stat.hiccup)
        else $error("Hiccup charge not stopped at the top of the band.");

    a_hiccup_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        latched_r && !srst_s && !vlow_s && !vhys_s |=> $stable(hiccup_r))
        else $error("Hiccup charge changed inside the band.");

    a_latch_count: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(latched_r) |-> cnt_r == CNT_W'(EVENTS))
        else $error("Latch entered with a count other than the event limit.");

    a_cnt_range: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        cnt_r <= CNT_W'(EVENTS))
        else $error("Event count beyond the event limit.");

    a_evt_offtime: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        evt |-> !$past(o_drv))
        else $error("Fault event raised while the drive was on.");

    a_evt_single: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        evt |=> !evt)
        else $error("Fault event longer than one cycle.");

    a_hit_mark: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        evt |=> cyc_hit_r)
        else $error("Event not recorded for the current switching cycle.");

    a_hit_drop: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_cycle_start && !evt |=> !cyc_hit_r)
        else $error("Event record not cleared at the start of a cycle.");

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Cycle starts seen since the count left zero; a latch needs one start per extra event.
    logic [CNT_W-1:0] cyc_seen_r;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cyc_seen_r <= CNT_RST;
        end else if (cnt_r == CNT_RST) begin
            cyc_seen_r <= CNT_RST;
        end else if (i_cycle_start && cyc_seen_r != '1) begin
            cyc_seen_r <= cyc_seen_r + 1'b1;
        end
    end

    a_cycles_span: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $rose(latched_r) |-> cyc_seen_r >= CNT_W'(EVENTS - 1))
        else $error("Latch reached in fewer switching cycles than successive events.");

endmodule // fault_latch_qualifier

/* src/flq_pkg.sv */
// Shared constants and types of the fault latch qualifier.
package flq_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int T_BLANK_NS = 2500;
    localparam int T_QUAL_NS = 1000;
    // Both intervals round up so neither the mask nor the persistence test is shortened.
    localparam int BLANK_CYC = (T_BLANK_NS * CLK_MHZ + 999) / 1000;
    localparam int QUAL_CYC = (T_QUAL_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------
    // Event counting
    // ------------------------------------------------------------
    localparam int EVT_LATCH = 4;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] CNT_RST = 3'h0;
    localparam int SYNC_W = 4;
    localparam int SY_CMP = 0;
    localparam int SY_SRST = 1;
    localparam int SY_VLOW = 2;
    localparam int SY_VHYS = 3;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FLQ_ON,
        FLQ_BLANK,
        FLQ_WATCH,
        FLQ_DONE
    } flq_qstate_e;

    typedef struct packed {
        logic latched;
        logic hiccup;
        logic [CNT_W-1:0] evt_cnt;
    } flq_stat_s;

endpackage

/* src/flq_qualify.sv */
// Blanking and persistence qualification of the latch comparator, one event per off-time.
module flq_qualify #(
    parameter int BLANK = flq_pkg::BLANK_CYC,
    parameter int QUAL = flq_pkg::QUAL_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_drv,
    input wire logic i_cmp,
    output logic o_event
);
    import flq_pkg::*;

    localparam int BW = $clog2(BLANK + 1);
    localparam int RW = $clog2(QUAL + 1);
    localparam logic [BW-1:0] BLANK_LD = BW'(BLANK - 1);
    localparam logic [RW-1:0] QUAL_LAST = RW'(QUAL - 1);
    localparam logic [RW-1:0] QUAL_MAX = RW'(QUAL);

    flq_qstate_e state_r, state_nxt;
    logic [BW-1:0] tmr_r, tmr_nxt;
    logic [RW-1:0] run_r, run_nxt;
    logic drv_d_r;
    logic event_nxt;
    logic [RW-1:0] hi_len_r;

    wire drv_fall = drv_d_r & ~i_drv;
    wire run_full = (run_r == QUAL_LAST);

    always_comb begin
        state_nxt = state_r;
        tmr_nxt = tmr_r;
        run_nxt = run_r;
        event_nxt = 1'b0;
        case (state_r)
            FLQ_ON: begin
                if (drv_fall) begin
                    state_nxt = FLQ_BLANK;
                    tmr_nxt = BLANK_LD;
                end
            end
            FLQ_BLANK: begin
                if (i_drv) begin
                    state_nxt = FLQ_ON;
                end else if (tmr_r == '0) begin
                    state_nxt = FLQ_WATCH;
                    run_nxt = '0;
                end else begin
                    tmr_nxt = tmr_r - 1'b1;
                end
            end
            FLQ_WATCH: begin
                if (i_drv) begin
                    state_nxt = FLQ_ON;
                end else if (!i_cmp) begin
                    run_nxt = '0;
                end else if (run_full) begin
                    state_nxt = FLQ_DONE;
                    event_nxt = 1'b1;
                end else begin
                    run_nxt = run_r + 1'b1;
                end
            end
            FLQ_DONE: begin
                if (i_drv) begin
                    state_nxt = FLQ_ON;
                end
            end
            default: state_nxt = FLQ_ON;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_r <= FLQ_ON;
            tmr_r <= '0;
            run_r <= '0;
            drv_d_r <= 1'b0;
            o_event <= 1'b0;
        end else begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            run_r <= run_nxt;
            drv_d_r <= i_drv;
            o_event <= event_nxt;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            hi_len_r <= '0;
        end else if (!i_cmp) begin
            hi_len_r <= '0;
        end else if (hi_len_r != QUAL_MAX) begin
            hi_len_r <= hi_len_r + 1'b1;
        end
    end

    a_blank_entry: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        $fell(i_drv) |=> state_r == FLQ_BLANK)
        else $error("Turn-off edge did not start the blanking interval.");

    a_blank_mask: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        state_r == FLQ_BLANK |-> !o_event && !event_nxt)
        else $error("Fault event raised during blanking.");

    a_qual_persist: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_event |-> hi_len_r >= QUAL_MAX)
        else $error("Fault event from a comparator high shorter than the qualification time.");

    a_once_offtime: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        o_event |-> !$past(i_drv) && state_r == FLQ_DONE ##1 !o_event)
        else $error("More than one fault event in an off-time.");

endmodule // flq_qualify
